// *** rtl/fmsr_map.vh ***
// constants for the flash mode, security and reset control block
`ifndef FMSR_MAP_VH
`define FMSR_MAP_VH
// register offsets on the plain register port
`define FMSR_ADDR_CNFG     4'h0
`define FMSR_ADDR_STAT     4'h1
`define FMSR_ADDR_PROT     4'h2
`define FMSR_ADDR_SEC      4'h3
`define FMSR_ADDR_CTL      4'h4
`define FMSR_ADDR_KEY_BASE 4'h8
// configuration register fields
`define FMSR_CNFG_BEIE     7
`define FMSR_CNFG_COMPLETE_IRQ_ENABLE     6
`define FMSR_CNFG_KEY_ACCESS_BIT   5
`define FMSR_CNFG_DFIE     4
// status register fields
`define FMSR_STAT_BEIF     7
`define FMSR_STAT_COMMAND_COMPLETE_FLAG     6
`define FMSR_STAT_ACCESS_ERROR_FLAG   4
`define FMSR_STAT_DFIF     1
// protection register fields
`define FMSR_PROT_OPEN     7
// security register fields
`define FMSR_SEC_LO        0
`define FMSR_SEC_HI        1
`define FMSR_KEY_ENABLE_FIELD_LO      6
`define FMSR_KEY_ENABLE_FIELD_HI      7
// encodings
`define FMSR_SEC_UNSECURE  2'h2
`define FMSR_KEY_ENABLE_FIELD_ON      2'h2
`define FMSR_KEY_ZERO      16'h0000
`define FMSR_KEY_ONES      16'hffff
// reset values and double-fault fallbacks
`define FMSR_PROT_FAULT    8'h7f
`define FMSR_ALL_ONES      8'hff
`define FMSR_CNFG_RST      8'h00
`define FMSR_STAT_RST      8'hc0
`endif

// *** rtl/fmsr_ctrl.v ***
// flash mode, security, reset load and interrupt control block
// Notes on behaviour
// - wait mode lets commands finish normally
// - buffer-empty and complete interrupts wake from wait
// - stop aborts command, cuts high voltage, flags
// - stop exit sets buffer-empty, drops queued command
// - debug mode may write protection; commands allowed
// - security taken from stored byte each reset
// - key access compares writes; reads invalid
// - four matching keys force unsecure code
// - illegal key sequence locks machine secured
// - lock stays until next reset
// - unlock leaves stored bytes and protection alone
// - no backdoor unlock via debug in special mode
// - debug unsecure bit overrides stored security
// - processor stalled while reset loads registers
// - protection fault clears open, sets others
// - control or security fault sets all bits
// - any reset-load fault sets access error
// - reset drives no abort; only stop entry aborts a command
// - three interrupts gated by enable and mask
// - stop entry during a command sets access error; any stop entry purges pending
`include "fmsr_map.vh"
`default_nettype none
module fmsr_ctrl #(
    parameter KEY_W = 16  // width of one backdoor key word
) (
    // clock, reset, enable
    input  wire        clock,
    input  wire        rst,
    input  wire        ce,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // mode inputs
    input  wire        wait_mode,
    input  wire        stop_mode,
    input  wire        background_debug_mode,
    input  wire        special_single_chip,
    input  wire        debug_unsecure_bit,
    input  wire        global_irq_mask,
    // reset-time load from array
    output reg         load_req,
    output reg  [1:0]  load_sel,
    input  wire        load_ack,
    input  wire [7:0]  load_data,
    input  wire        load_fault,
    // command engine
    input  wire        cmd_active,
    input  wire        cmd_queued,
    input  wire        cmd_done,
    input  wire        cmd_fault,
    output wire        cmd_abort,
    output wire        queue_purge,
    output wire        hv_enable,
    // backdoor key write and stored key
    input  wire        key_wr,
    input  wire [1:0]  key_index,
    input  wire [KEY_W-1:0] key_data,
    input  wire [KEY_W-1:0] key_stored,
    input  wire        key_from_debug,
    // outputs to the chip
    output wire        cpu_stall,
    output wire        read_invalid,
    output wire        chip_secure,
    output wire        irq_command,
    output wire        irq_fault
);
    // loader fills stored registers at reset
    // then port, flags and key machine run
    // ce low freezes all state, so a stopped
    // bus clock keeps a key sequence intact
    // mode pins arrive synchronous to clock
    // engine and array sit outside; only
    // abort, purge, pump and load request and select leave from here
    // keys heard only once security is in
    // loader order: prot, then ctl, then sec
    // no retries anywhere; faults fall back
    // load sequencer states
    localparam LD_PROT = 2'h0;
    localparam LD_CTL  = 2'h1;
    localparam LD_SEC  = 2'h2;
    localparam LD_DONE = 2'h3;
    // key machine states
    localparam KS_IDLE = 2'h0;
    localparam KS_RUN  = 2'h1;
    localparam KS_LOCK = 2'h2;
    localparam KS_OPEN = 2'h3;
    // idle waits for word zero, run counts
    // lock and open hold until rst; software
    // cannot leave either state

    // live copies; the array is never written,
    // so an unlock leaves the stored byte alone
    reg  [1:0] ld_q;         // reset load step
    reg  [7:0] prot_q;       // protection register
    reg  [7:0] ctl_q;        // nonvolatile control register
    reg  [7:0] sec_q;        // security register
    reg  [7:0] cnfg_q;       // configuration register
    reg        beif_q;       // buffer empty flag
    reg        command_complete_flag_q;       // command complete flag
    reg        access_error_flag_q;     // access error flag
    reg        dfif_q;       // double fault flag
    reg  [1:0] ks_q;         // key machine state
    reg  [2:0] kidx_q;       // next expected key index
    reg        kprev_q;      // key write on previous cycle
    reg        kbad_q;       // mismatch seen in this attempt
    reg        stop_q;       // stop level, previous cycle
    wire       stop_enter;   // stop rising edge
    wire       stop_exit;    // stop falling edge
    wire       key_access_bit;       // key access bit
    wire       key_ok;       // key enable field enabled
    wire       key_illegal;  // order, count, value or spacing fault
    wire [7:0] stat_w;       // status read value

    // decoded fields and stop edges
    // stop_q resets low like the idle pin,
    // so no false stop exit follows reset
    assign key_access_bit      = cnfg_q[`FMSR_CNFG_KEY_ACCESS_BIT];
    assign key_ok      = (sec_q[`FMSR_KEY_ENABLE_FIELD_HI:`FMSR_KEY_ENABLE_FIELD_LO] == `FMSR_KEY_ENABLE_FIELD_ON);
    assign stop_enter  = stop_mode & ~stop_q;
    assign stop_exit   = ~stop_mode & stop_q;
    assign stat_w      = {beif_q, command_complete_flag_q, 1'b0, access_error_flag_q, 2'b00, dfif_q, 1'b0};

    // stall cpu until all three registers are loaded
    // running early would expose a secured
    // part while sec still holds reset value
    assign cpu_stall   = (ld_q != LD_DONE);
    // abort on stop entry; wait mode leaves commands running
    // wait needs no term: engine keeps going,
    // so active and queued commands complete
    // abort pulses on the stop edge only
    assign cmd_abort   = stop_enter & cmd_active;
    assign queue_purge = stop_enter | stop_exit;
    // high voltage cut as soon as stop is seen
    // level, not edge: pump off all of stop
    // even if cmd_active drops late
    assign hv_enable   = cmd_active & ~stop_mode;
    // array reads are junk while key access is on and the key enable field is on
    // read path swaps in filler on this flag
    assign read_invalid = key_access_bit & key_ok;
    // debug unsecure overrides stored security
    // debug path beats byte and key machine;
    // sec_q zero in reset reads as secured
    assign chip_secure = ~debug_unsecure_bit &
        (sec_q[`FMSR_SEC_HI:`FMSR_SEC_LO] != `FMSR_SEC_UNSECURE);
    // interrupts, usable in wait mode to wake the core
    // no stored edge: request holds until
    // flag or enable is cleared
    assign irq_command = ~global_irq_mask &
        ((beif_q & cnfg_q[`FMSR_CNFG_BEIE]) | (command_complete_flag_q & cnfg_q[`FMSR_CNFG_COMPLETE_IRQ_ENABLE]));
    assign irq_fault   = ~global_irq_mask & dfif_q & cnfg_q[`FMSR_CNFG_DFIE];

    // kidx_q[2]: four words in, a fifth locks
    // kprev_q catches successive-clock writes,
    // even of correct words in order
    // a key write is illegal if out of order, too many, reserved value or back to back
    assign key_illegal = (kidx_q[2] | ({1'b0, key_index} != kidx_q) |
        (key_data == `FMSR_KEY_ZERO) | (key_data == `FMSR_KEY_ONES) | kprev_q);

    // load request mirrors sequencer step
    // select is the step code itself,
    // so no decode lag toward the array
    always @* begin
        load_req = (ld_q != LD_DONE);
        load_sel = ld_q;
    end

    // read data one cycle after the strobe
    // zero when no read, so stale data never
    // lingers on a shared read path
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            // idle cycles read as zero
            if (!reg_rd) begin
                reg_rdata <= 8'h00;
            end else if (reg_addr == `FMSR_ADDR_CNFG) begin
                reg_rdata <= cnfg_q;
            end else if (reg_addr == `FMSR_ADDR_STAT) begin
                reg_rdata <= stat_w;
            end else if (reg_addr == `FMSR_ADDR_PROT) begin
                reg_rdata <= prot_q;
            end else if (reg_addr == `FMSR_ADDR_SEC) begin
                reg_rdata <= sec_q;
            end else if (reg_addr == `FMSR_ADDR_CTL) begin
                reg_rdata <= ctl_q;
            end else begin
                reg_rdata <= 8'h00; // unmapped reads zero
            end
        end
    end

    // reset load sequencer and loaded registers
    // one ack per step; a slow array only
    // stretches the stall
    // a fault takes the safe fallback, so
    // the load always ends
    // afterwards owns the debug prot write
    // and the unlock forcing of sec
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ld_q   <= LD_PROT; // every reset restarts the load
            prot_q <= 8'h00;
            ctl_q  <= 8'h00;
            sec_q  <= 8'h00;
        end else if (ce) begin
            case (ld_q)
                // first step after every reset
                LD_PROT: begin
                    if (load_ack) begin
                        // fault: open bit clear, rest set
                        prot_q <= load_fault ? `FMSR_PROT_FAULT : load_data;
                        ld_q   <= LD_CTL;
                    end
                end
                LD_CTL: begin
                    if (load_ack) begin
                        // fault: every control bit set
                        ctl_q <= load_fault ? `FMSR_ALL_ONES : load_data;
                        ld_q  <= LD_SEC;
                    end
                end
                // last step; secured on fault
                LD_SEC: begin
                    if (load_ack) begin
                        // fault leaves chip secure, keys disabled
                        sec_q <= load_fault ? `FMSR_ALL_ONES : load_data;
                        ld_q  <= LD_DONE;
                    end
                end
                default: begin
                    // protection writable in debug mode only
                    // other writes dropped silently
                    if (reg_wr && reg_addr == `FMSR_ADDR_PROT && background_debug_mode) begin
                        prot_q <= reg_wdata;
                    end
                    // unlock forces only the live field, stored byte untouched
                    // a key write on this edge locks,
                    // so it must not open here either
                    if (ks_q == KS_RUN && !key_access_bit && !key_wr && kidx_q[2] && !kbad_q) begin
                        sec_q[`FMSR_SEC_HI:`FMSR_SEC_LO] <= `FMSR_SEC_UNSECURE;
                    end
                end
            endcase
        end
    end

    // configuration register, software written
    // unguarded; the key machine judges
    // whether a key access change was legal
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cnfg_q <= `FMSR_CNFG_RST;
        end else if (ce && reg_wr && reg_addr == `FMSR_ADDR_CNFG) begin
            cnfg_q <= reg_wdata;
        end
    end

    // status flags; hardware set wins over software clear
    // set terms stand below clear terms,
    // so the last assignment wins
    // beif_q drops while a command waits,
    // returns on stop exit with the purge
    // command_complete_flag_q follows the engine each cycle;
    // only the abort forces it high
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            beif_q   <= 1'b1;
            command_complete_flag_q   <= 1'b1;
            access_error_flag_q <= 1'b0;
            dfif_q   <= 1'b0;
            stop_q   <= 1'b0;
        end else if (ce) begin
            // edge copy advances only when enabled
            stop_q <= stop_mode;
            // write one to clear
            // only access error and double fault
            if (reg_wr && reg_addr == `FMSR_ADDR_STAT) begin
                if (reg_wdata[`FMSR_STAT_ACCESS_ERROR_FLAG]) begin
                    access_error_flag_q <= 1'b0;
                end
                if (reg_wdata[`FMSR_STAT_DFIF]) begin
                    dfif_q <= 1'b0;
                end
            end
            // complete when idle or just finished
            command_complete_flag_q <= ~cmd_active | cmd_done;
            // double fault on an engine read
            if (cmd_fault) begin
                dfif_q   <= 1'b1;
                access_error_flag_q <= 1'b1;
            end
            // faulted reset-time read
            if (load_ack && load_fault && ld_q != LD_DONE) begin
                access_error_flag_q <= 1'b1;
            end
            if (cmd_abort) begin
                command_complete_flag_q   <= 1'b1;
                access_error_flag_q <= 1'b1;
            end
            // stop exit beats a queue entry
            if (stop_exit) begin
                beif_q <= 1'b1;
            end else if (cmd_queued) begin
                beif_q <= 1'b0;
            end
        end
    end

    // backdoor key state machine
    // compares gather in kbad_q, judged at
    // key access clear, so no early hint
    // key reads are plain data: a double
    // fault on them is ignored
    // writes before load done are ignored
    // since key enable is not known yet
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ks_q    <= KS_IDLE; // reset leaves lock
            kidx_q  <= 3'h0;
            kprev_q <= 1'b0;
            kbad_q  <= 1'b0;
        end else if (ce) begin
            // spacing judged while key access on
            kprev_q <= key_wr & key_access_bit;
            case (ks_q)
                // first word: index zero, legal
                KS_IDLE: begin
                    if (key_wr && key_access_bit && key_ok && ld_q == LD_DONE) begin
                        if ((key_from_debug && special_single_chip) || key_illegal) begin
                            ks_q <= KS_LOCK;
                        end else begin
                            ks_q   <= KS_RUN;
                            kidx_q <= 3'h1;
                            kbad_q <= (key_data != key_stored);
                        end
                    end
                end
                // later words: next index, spaced
                KS_RUN: begin
                    if (key_wr) begin
                        if (key_illegal || !key_access_bit ||
                            (key_from_debug && special_single_chip)) begin
                            ks_q <= KS_LOCK;
                        end else begin
                            kidx_q <= kidx_q + 3'h1;
                            kbad_q <= kbad_q | (key_data != key_stored);
                        end
                    end else if (!key_access_bit) begin
                        // dropped early or mismatch locks; full match opens
                        ks_q <= (kidx_q[2] && !kbad_q) ? KS_OPEN : KS_LOCK;
                    end
                end
                // dead end until rst
                KS_LOCK: begin
                    ks_q <= KS_LOCK;
                end
                default: begin
                    // open: unsecured until next reset
                    ks_q <= KS_OPEN;
                end
            endcase
        end
    end
endmodule // fmsr_ctrl
`default_nettype wire

// *** sim/fmsr_checker.sv ***
// assertion checker for the flash mode, security and reset control block
`include "fmsr_map.vh"
`default_nettype none
module fmsr_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       ce,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // modes
    input wire logic       stop_mode,
    input wire logic       wait_mode,
    input wire logic       global_irq_mask,
    // reset load
    input wire logic       load_req,
    input wire logic [1:0] load_sel,
    input wire logic       load_ack,
    // command engine and chip outputs
    input wire logic       cmd_active,
    input wire logic       cmd_abort,
    input wire logic       queue_purge,
    input wire logic       hv_enable,
    input wire logic       cpu_stall,
    input wire logic       irq_command,
    input wire logic       irq_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // stop entered while a command runs
    sequence s_abort;
        $rose(stop_mode) && cmd_active;
    endsequence
    // status read right behind it
    sequence s_stat_rd;
        reg_rd && ce && reg_addr == `FMSR_ADDR_STAT;
    endsequence
    a_stop_abort: assert property (s_abort |-> cmd_abort)
        else $error("abort missing on stop entry");
    a_hv_cut: assert property (stop_mode |-> !hv_enable)
        else $error("high voltage on in stop");
    a_stop_flags: assert property (s_abort ##1 s_stat_rd |=>
        reg_rdata[`FMSR_STAT_ACCESS_ERROR_FLAG] && reg_rdata[`FMSR_STAT_COMMAND_COMPLETE_FLAG])
        else $error("stop abort flags not set");
    a_exit_purge: assert property ($fell(stop_mode) |-> queue_purge)
        else $error("queued command kept on stop exit");
    a_wait_runs: assert property (wait_mode && cmd_active && !stop_mode |-> hv_enable)
        else $error("command cut in wait mode");
    a_load_stall: assert property (load_req |-> cpu_stall)
        else $error("processor runs during load");
    a_load_step: assert property (load_ack && load_sel == 2'h0 |=> load_sel == 2'h1)
        else $error("load order broken");
    a_load_done: assert property (load_ack && load_sel == 2'h2 |=> !cpu_stall && !load_req)
        else $error("stall kept after load");
    a_irq_mask: assert property (global_irq_mask |-> !irq_command && !irq_fault)
        else $error("interrupt passes global mask");
endmodule // fmsr_checker
`default_nettype wire

// *** sim/fmsr_array_model.sv ***
// partner model: flash array answering reset-time loads and key lookups
`default_nettype none
module fmsr_array_model #(
    parameter logic [7:0]  PROT_VAL = 8'h8f,  // stored protection byte
    parameter logic [7:0]  CTL_VAL  = 8'h3c,  // stored control byte
    parameter logic [7:0]  SEC_VAL  = 8'h80,  // stored security byte
    parameter logic [63:0] KEYS     = 64'h0   // stored key words, word 0 lowest
) (
    // clock and reset
    input wire logic         clock,
    input wire logic         rst,
    // load handshake
    input wire logic         load_req,
    input wire logic [1:0]   load_sel,
    output var logic         load_ack,
    output logic [7:0]       load_data,
    output logic             load_fault,
    // scenario controls
    input wire logic         fault_on,
    input wire logic         slow,
    // key lookup
    input wire logic [1:0]   key_index,
    output logic [15:0]      key_stored
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;  // cycles spent on the current load
    logic [7:0] val;     // byte of the selected field
    assign val = (load_sel == 2'h0) ? PROT_VAL : (load_sel == 2'h1) ? CTL_VAL : SEC_VAL;
    // data only valid with the ack; otherwise inverted so stale values never pass
    assign load_data = load_ack ? val : ~val;
    assign load_fault = load_ack & fault_on;
    assign key_stored = KEYS[key_index*16 +: 16];
    // one ack per field, prompt or slow; skip the ack cycle so sel can advance
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 4'h0;
            load_ack <= 1'b0;
        end else begin
            load_ack <= 1'b0;
            if (load_req && !load_ack) begin
                if (wait_q == (slow ? 4'h5 : 4'h1)) begin
                    load_ack <= 1'b1;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule // fmsr_array_model
`default_nettype wire

// *** sim/fmsr_ctrl_test.sv ***
// self-checking testbench for the flash mode, security and reset control block
`include "fmsr_map.vh"
`default_nettype none
module fmsr_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] KEYS = 64'h4d2c_19e7_a53b_6f81;  // stored keys
    typedef struct {string name; logic [7:0] exp; logic [7:0] mask;} fmsr_note_t;
    logic clock = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, load_data, v;
    logic wait_mode = 0, stop_mode = 0, background_debug_mode = 0, special_single_chip = 0;
    logic debug_unsecure_bit = 0, global_irq_mask = 0, load_req, load_ack, load_fault;
    logic [1:0] load_sel, key_index = 0;
    logic cmd_active = 0, cmd_queued = 0, cmd_done = 0, cmd_fault = 0, cmd_abort;
    logic queue_purge, hv_enable, key_wr = 0, key_from_debug = 0, cpu_stall, read_invalid;
    logic chip_secure, irq_command, irq_fault, fault_on = 0, slow = 0;
    logic [15:0] key_data = 0, key_stored, w;
    int err_count = 0, total_checks = 0, seed = 32'h2c04;
    fmsr_note_t q[$];   // expected read data, oldest first
    fmsr_note_t n;
    fmsr_ctrl DUT (.clock, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .wait_mode, .stop_mode, .background_debug_mode, .special_single_chip,
        .debug_unsecure_bit, .global_irq_mask, .load_req, .load_sel, .load_ack, .load_data,
        .load_fault, .cmd_active, .cmd_queued, .cmd_done, .cmd_fault, .cmd_abort,
        .queue_purge, .hv_enable, .key_wr, .key_index, .key_data, .key_stored,
        .key_from_debug, .cpu_stall, .read_invalid, .chip_secure, .irq_command, .irq_fault);
    fmsr_array_model #(.KEYS(KEYS)) u_array (.clock, .rst, .load_req, .load_sel, .load_ack,
        .load_data, .load_fault, .fault_on, .slow, .key_index, .key_stored);
    always #10 clock = ~clock;
    // compare and count
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clock) rd_d <= reg_rd;
    always @(negedge clock) begin
        if (rd_d) begin
            n = q.pop_front();
            cmp(n.name, n.exp, reg_rdata & n.mask);
        end
    end
    // bus tasks start and end just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e,
            input logic [7:0] m);
        reg_rd <= 1'b1; reg_addr <= a;
        q.push_back('{nm, e & m, m});
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask
    // combinational output seen mid-cycle
    task automatic look(input string nm, input logic [7:0] e, ref logic s);
        @(negedge clock);
        cmp(nm, e, {7'h0, s});
        @(posedge clock);
    endtask
    task automatic do_reset(input logic flt);
        int i;
        i = 0;
        fault_on <= flt;
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        while (i < 100 && cpu_stall !== 1'b0) begin
            @(negedge clock);
            i++;
        end
        cmp("stall", 8'h0, {7'h0, cpu_stall});
        @(posedge clock);
    endtask
    // key access, four words, then clear; gap 0 writes back to back
    task automatic unlock(input int gap, input logic [15:0] w0);
        wr(`FMSR_ADDR_CNFG, 8'h20);
        for (int i = 0; i < 4; i++) begin
            key_wr <= 1'b1; key_index <= i[1:0];
            key_data <= (i == 0) ? w0 : KEYS[i*16 +: 16];
            @(posedge clock);
            if (gap > 0) key_wr <= 1'b0;
            repeat (gap) @(posedge clock);
        end
        key_wr <= 1'b0;
        wr(`FMSR_ADDR_CNFG, 8'h00);
        repeat (3) @(posedge clock);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        end_sim;
    end
    initial begin
        do_reset(1'b0);
        rd("sec", `FMSR_ADDR_SEC, 8'h80, 8'hff);
        rd("prot", `FMSR_ADDR_PROT, 8'h8f, 8'hff);
        rd("ctl", `FMSR_ADDR_CTL, 8'h3c, 8'hff);
        ce <= 1'b0;
        wr(`FMSR_ADDR_CNFG, 8'hff);
        ce <= 1'b1;
        rd("cnfg", `FMSR_ADDR_CNFG, 8'h00, 8'hff);
        look("secure", 8'h1, chip_secure);
        wr(`FMSR_ADDR_CNFG, 8'h20);
        look("invalid", 8'h1, read_invalid);
        unlock(2, KEYS[15:0]);
        look("secure", 8'h0, chip_secure);
        rd("sec", `FMSR_ADDR_SEC, 8'h82, 8'hff);
        rd("prot", `FMSR_ADDR_PROT, 8'h8f, 8'hff);
        do_reset(1'b0);
        look("secure", 8'h1, chip_secure);
        unlock(0, KEYS[15:0]);
        unlock(2, KEYS[15:0]);
        look("secure", 8'h1, chip_secure);
        do_reset(1'b0);
        unlock(2, 16'h0000);
        look("secure", 8'h1, chip_secure);
        do_reset(1'b0);
        w = $random(seed);
        unlock(2, (w == KEYS[15:0]) ? ~w : w);
        look("secure", 8'h1, chip_secure);
        do_reset(1'b0);
        unlock(2, KEYS[15:0]);
        look("secure", 8'h0, chip_secure);
        do_reset(1'b0);
        key_from_debug <= 1'b1;
        special_single_chip <= 1'b1;
        unlock(2, KEYS[15:0]);
        look("secure", 8'h1, chip_secure);
        key_from_debug <= 1'b0;
        special_single_chip <= 1'b0;
        debug_unsecure_bit <= 1'b1;
        do_reset(1'b0);
        look("secure", 8'h0, chip_secure);
        debug_unsecure_bit <= 1'b0;
        v = $random(seed);
        wr(`FMSR_ADDR_PROT, v);
        rd("prot", `FMSR_ADDR_PROT, 8'h8f, 8'hff);
        background_debug_mode <= 1'b1;
        wr(`FMSR_ADDR_PROT, v);
        rd("prot", `FMSR_ADDR_PROT, v, 8'hff);
        background_debug_mode <= 1'b0;
        cmd_active <= 1'b1; cmd_queued <= 1'b1; wait_mode <= 1'b1;
        look("hv", 8'h1, hv_enable);
        wait_mode <= 1'b0; stop_mode <= 1'b1;
        look("abort", 8'h1, cmd_abort);
        cmd_active <= 1'b0; cmd_queued <= 1'b0;
        rd("stat", `FMSR_ADDR_STAT, 8'h50, 8'h50);
        wr(`FMSR_ADDR_STAT, 8'h10);
        rd("stat", `FMSR_ADDR_STAT, 8'h00, 8'h10);
        stop_mode <= 1'b0;
        look("purge", 8'h1, queue_purge);
        rd("stat", `FMSR_ADDR_STAT, 8'h80, 8'h80);
        wr(`FMSR_ADDR_CNFG, 8'h50);
        look("irq", 8'h1, irq_command);
        cmd_fault <= 1'b1;
        @(posedge clock);
        cmd_fault <= 1'b0;
        look("irq", 8'h1, irq_fault);
        global_irq_mask <= 1'b1;
        look("irq", 8'h0, irq_fault);
        global_irq_mask <= 1'b0;
        slow <= 1'b1;
        do_reset(1'b1);
        rd("prot", `FMSR_ADDR_PROT, 8'h7f, 8'hff);
        rd("ctl", `FMSR_ADDR_CTL, 8'hff, 8'hff);
        rd("sec", `FMSR_ADDR_SEC, 8'hff, 8'hff);
        rd("stat", `FMSR_ADDR_STAT, 8'h10, 8'h10);
        look("secure", 8'h1, chip_secure);
        end_sim;
    end
endmodule // fmsr_ctrl_test
bind fmsr_ctrl fmsr_checker u_chk (.clock, .rst, .ce, .reg_addr, .reg_rd, .reg_rdata,
    .stop_mode, .wait_mode, .global_irq_mask, .load_req, .load_sel, .load_ack, .cmd_active,
    .cmd_abort, .queue_purge, .hv_enable, .cpu_stall, .irq_command, .irq_fault);
`default_nettype wire
